// File: motion_io_supervisor_regs.svh
`ifndef MOTION_IO_SUPERVISOR_REGS_SVH
`define MOTION_IO_SUPERVISOR_REGS_SVH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_CMD         8'h04
`define OFS_RAMP        8'h08
`define OFS_STATUS      8'h0c
`define OFS_STEP_POS    8'h10
`define OFS_ENC_POS     8'h14
// analog sample lives in general register 12, one word each
`define OFS_ADC         8'h30

// control word fields
`define CTRL_MODE_LSB   0
`define CTRL_EACT_LSB   4
`define CTRL_HMAP_LSB   8
`define CTRL_POL_CW     12
`define CTRL_POL_CCW    13
`define CTRL_POL_HOME   14
`define CTRL_HOME_DIR   16
`define CTRL_HOME_MARK  17
`define CTRL_AMP_EN     18
`define CTRL_RST        32'h0002_0004

// command word bits (write-one pulses)
`define CMD_CLR_ERR     0
`define CMD_HOME        1
`define CMD_RESTART     2

`define MODE_STEP_DIR   3'h5
`define RAMP_RST        16'h0064

// timing
`define CLK_KHZ         40000
`define ESTOP_PERIOD_US 1000
`define SERVO_PERIOD_US 1000
`define STEP_MAX_KHZ    1000
`define ENC_EDGE_MIN_NS 100

`endif

// File: motion_io_pkg.sv
package motion_io_pkg;

	typedef enum logic [3:0] {
		HOME_IDLE  = 4'b0001,
		HOME_SEEK  = 4'b0010,
		HOME_LEAVE = 4'b0100,
		HOME_MARK  = 4'b1000
	} home_state_t;

	typedef enum logic [1:0] {
		EACT_COAST = 2'h0,
		EACT_HOLD  = 2'h1,
		EACT_STOP_OFF = 2'h2
	} estop_act_t;

endpackage

// File: quad_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface quad_link_if;
	logic        a;
	logic        b;
	logic        idx;
	logic [31:0] count;
	logic        idx_pulse;
	logic        err;
	modport src (output a, b, idx, input count, idx_pulse, err);
	modport dec (input a, b, idx, output count, idx_pulse, err);
endinterface
`default_nettype wire

// File: quad_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module quad_decoder (
	input  wire logic  pclk,    // system clock
	input  wire logic  presetn, // async reset, active low
	quad_link_if.dec   q        // synchronised channels in, count out
);
	logic [1:0]  prev_r;
	logic        idx_prev_r;
	logic [31:0] count_r;
	logic        idx_pulse_r;
	logic        err_r;
	logic [1:0]  cur;

	assign cur         = {q.a, q.b};
	assign q.count     = count_r;
	assign q.idx_pulse = idx_pulse_r;
	assign q.err       = err_r;

	// each edge of one channel alone counts; gray order gives direction, both changing at once flags an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r  <= 2'h0;
			count_r <= 32'h0000_0000;
			err_r   <= 1'b0;
		end else begin
			prev_r <= cur;
			err_r  <= 1'b0;
			case ({prev_r, cur})
				4'b0001, 4'b0111, 4'b1110, 4'b1000: count_r <= count_r + 32'h1;
				4'b0010, 4'b1011, 4'b1101, 4'b0100: count_r <= count_r - 32'h1;
				4'b0011, 4'b1100, 4'b0110, 4'b1001: err_r <= 1'b1;
				default: count_r <= count_r;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_prev_r  <= 1'b0;
			idx_pulse_r <= 1'b0;
		end else begin
			idx_prev_r  <= q.idx;
			idx_pulse_r <= q.idx & ~idx_prev_r;
		end
	end
endmodule
`default_nettype wire

// File: motion_io_supervisor.sv
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "motion_io_supervisor_regs.svh"

// Contract
// - step pulses signed by direction form the position command; rate at most 1 MHz.
// - step mode applies only when mode equals 5 after a restart; latched each servo cycle.
// - emergency stop is sampled once every millisecond.
// - action 0: emergency stop cuts the power stage at once, motor coasts.
// - action 1: feed hold, controlled stop, power stage stays on.
// - action 2: controlled stop, then the power stage is cut.
// - controlled stop deceleration follows the ramp-time setting.
// - motor over-temperature aborts motion and cuts the power stage.
// - over-temperature stays latched until the fault-clear command is given.
// - each analog sample is stored in general register 12.
// - fault output shows amplifier faults only, never controller faults; the code also drives it from the latched over-temperature.
// - encoder two channels plus index up to 2.5 MHz; edges 100 ns apart.
// - an active travel limit blocks motion only toward that limit.
// - home command drives toward home in the preset direction until home limit.
// - then reverse and stop on the first index pulse after home releases.
// - each limit input has its own configurable polarity.
// - three Hall signals form a six-step pattern selecting commutation.
// - Hall low means phase positive in clockwise rotation.
// - Hall mapping setting selects phase relation; 0 is the factory default.
module motion_io_supervisor
	import motion_io_pkg::*;
#(
	parameter int unsigned ESTOP_CYC = `CLK_KHZ * `ESTOP_PERIOD_US / 1000,
	parameter int unsigned SERVO_CYC = `CLK_KHZ * `SERVO_PERIOD_US / 1000
) (
	input  wire logic        pclk,           // system clock
	input  wire logic        presetn,        // async reset, active low
	input  wire logic        psel,           // apb select
	input  wire logic        penable,        // apb enable
	input  wire logic        pwrite,         // apb direction
	input  wire logic [7:0]  paddr,          // apb byte address
	input  wire logic [31:0] pwdata,         // apb write data
	output logic      [31:0] prdata,         // apb read data
	output logic             pready,         // apb ready
	output logic             pslverr,        // apb error
	input  wire logic        step_clk,       // step clock pin
	input  wire logic        step_dir,       // direction pin, 1 = clockwise
	input  wire logic        encoder_channel_a, // encoder a
	input  wire logic        encoder_channel_b, // encoder b
	input  wire logic        encoder_index_pulse, // encoder index
	input  wire logic        clockwise_travel_stop, // cw limit raw
	input  wire logic        counterclockwise_travel_stop, // ccw limit raw
	input  wire logic        home_limit,     // home limit raw
	input  wire logic [2:0]  hall,           // hall a,b,c raw
	input  wire logic        estop,          // emergency stop, high = asserted
	input  wire logic        thermistor,     // high = over temperature
	input  wire logic        amp_fault_in,   // power stage fault
	input  wire logic [9:0]  adc_data,       // analog sample
	input  wire logic        adc_valid,      // sample strobe, same clock
	output logic             power_stage_en, // power stage enable
	output logic             amp_fault_out,  // amplifier fault output
	output logic             cw_inhibit,     // block clockwise motion
	output logic             ccw_inhibit,    // block counterclockwise motion
	output logic             motion_abort,   // abort trajectory
	output logic      [15:0] hold_ramp,      // remaining decel ticks
	output logic             home_move,      // homing drive active
	output logic             home_dir,       // homing drive direction
	output logic      [31:0] step_pos,       // step command per servo cycle
	output logic      [2:0]  comm_state      // commutation sector
);
	localparam int NSYNC = 14;

	logic [NSYNC-1:0] sync1_r, sync2_r, prev_r;
	logic [31:0] ctrl_r;
	logic [15:0] ramp_time_r;
	logic [9:0]  adc_r;
	logic [31:0] step_acc_r, step_pos_r;
	logic        step_mode_r;
	logic [31:0] est_cnt_r, srv_cnt_r;
	logic        srv_tick_r, est_tick_r;
	logic        estop_r, ot_r, stop_act_r, power_r, fault_r, abort_r;
	logic [15:0] ramp_r;
	logic        cw_act_r, ccw_act_r, home_act_r, home_done_r;
	logic        cw_inh_r, ccw_inh_r;
	home_state_t home_st_r;
	logic        hmove_r, hdir_r;
	logic [2:0]  comm_r;
	logic        hall_err_r;
	logic [31:0] prdata_r;
	logic        pready_r, pslverr_r;
	logic        wr_en, rd_en, stop_req, stopped, kill, step_edge, step_cw;
	logic [2:0]  sector;
	logic        sector_ok;
	logic [3:0]  sec_sum;
	estop_act_t  eact;
	logic [31:0] status;

	quad_link_if qlink ();

	quad_decoder u_dec (
		.pclk    (pclk),
		.presetn (presetn),
		.q       (qlink.dec)
	);

	// two-stage input synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r  <= '0;
		end else begin
			sync1_r <= {amp_fault_in, thermistor, estop, hall, home_limit,
				counterclockwise_travel_stop, clockwise_travel_stop,
				encoder_index_pulse, encoder_channel_b, encoder_channel_a,
				step_dir, step_clk};
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	assign qlink.a   = sync2_r[2];
	assign qlink.b   = sync2_r[3];
	assign qlink.idx = sync2_r[4];
	assign eact      = estop_act_t'(ctrl_r[`CTRL_EACT_LSB +: 2]);

	// apb slave: one wait state, writes land on the pready edge
	assign wr_en = psel & penable & pready_r & pwrite;
	assign rd_en = psel & penable & ~pready_r & ~pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= psel & penable & ~pready_r;
			pslverr_r <= 1'b0;
			if (psel & penable & ~pready_r) begin
				case (paddr)
					`OFS_CTRL, `OFS_CMD, `OFS_RAMP, `OFS_STATUS,
					`OFS_STEP_POS, `OFS_ENC_POS, `OFS_ADC: pslverr_r <= 1'b0;
					default: pslverr_r <= 1'b1;
				endcase
			end
			if (rd_en) begin
				case (paddr)
					`OFS_CTRL:     prdata_r <= ctrl_r;
					`OFS_RAMP:     prdata_r <= {16'h0000, ramp_time_r};
					`OFS_STATUS:   prdata_r <= status;
					`OFS_STEP_POS: prdata_r <= step_pos_r;
					`OFS_ENC_POS:  prdata_r <= qlink.count;
					`OFS_ADC:      prdata_r <= {22'h000000, adc_r};
					default:       prdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r      <= `CTRL_RST;
			ramp_time_r <= `RAMP_RST;
		end else if (wr_en && paddr == `OFS_CTRL) begin
			ctrl_r <= pwdata;
		end else if (wr_en && paddr == `OFS_RAMP) begin
			ramp_time_r <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_r <= 10'h000;
		end else if (adc_valid) begin
			adc_r <= adc_data;
		end
	end

	// servo-cycle and estop-sample dividers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			srv_cnt_r  <= 32'h0000_0000;
			est_cnt_r  <= 32'h0000_0000;
			srv_tick_r <= 1'b0;
			est_tick_r <= 1'b0;
		end else begin
			srv_tick_r <= (srv_cnt_r == SERVO_CYC - 1);
			est_tick_r <= (est_cnt_r == ESTOP_CYC - 1);
			srv_cnt_r  <= (srv_cnt_r == SERVO_CYC - 1) ? 32'h0 : srv_cnt_r + 32'h1;
			est_cnt_r  <= (est_cnt_r == ESTOP_CYC - 1) ? 32'h0 : est_cnt_r + 32'h1;
		end
	end

	// limits with per-input polarity, 1 = active high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cw_act_r   <= 1'b0;
			ccw_act_r  <= 1'b0;
			home_act_r <= 1'b0;
			cw_inh_r   <= 1'b0;
			ccw_inh_r  <= 1'b0;
		end else begin
			cw_act_r   <= sync2_r[5] == ctrl_r[`CTRL_POL_CW];
			ccw_act_r  <= sync2_r[6] == ctrl_r[`CTRL_POL_CCW];
			home_act_r <= sync2_r[7] == ctrl_r[`CTRL_POL_HOME];
			cw_inh_r   <= cw_act_r;
			ccw_inh_r  <= ccw_act_r;
		end
	end

	// step/direction accumulator, mode fixed at restart
	assign step_edge = sync2_r[0] & ~prev_r[0];
	assign step_cw   = sync2_r[1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_mode_r <= 1'b0;
		end else if (wr_en && paddr == `OFS_CMD && pwdata[`CMD_RESTART]) begin
			step_mode_r <= ctrl_r[`CTRL_MODE_LSB +: 3] == `MODE_STEP_DIR;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_acc_r <= 32'h0000_0000;
			step_pos_r <= 32'h0000_0000;
		end else begin
			if (step_mode_r && step_edge && !abort_r) begin
				if (step_cw && !cw_act_r) begin
					step_acc_r <= step_acc_r + 32'h1;
				end else if (!step_cw && !ccw_act_r) begin
					step_acc_r <= step_acc_r - 32'h1;
				end
			end
			if (srv_tick_r && step_mode_r) begin
				step_pos_r <= step_acc_r;
			end
		end
	end

	// emergency stop and over-temperature supervision
	assign stop_req = estop_r && (eact == EACT_HOLD || eact == EACT_STOP_OFF);
	assign stopped  = stop_act_r && ramp_r == 16'h0000;
	assign kill     = estop_r && (eact == EACT_COAST || eact == 2'h3 ||
		(eact == EACT_STOP_OFF && stopped));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			estop_r <= 1'b0;
		end else if (est_tick_r) begin
			estop_r <= sync2_r[11];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ot_r <= 1'b0;
		end else if (sync2_r[12]) begin
			ot_r <= 1'b1;
		end else if (wr_en && paddr == `OFS_CMD && pwdata[`CMD_CLR_ERR]) begin
			ot_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_act_r <= 1'b0;
			ramp_r     <= 16'h0000;
		end else if (!stop_req) begin
			stop_act_r <= 1'b0;
			ramp_r     <= 16'h0000;
		end else if (!stop_act_r) begin
			stop_act_r <= 1'b1;
			ramp_r     <= ramp_time_r;
		end else if (srv_tick_r && ramp_r != 16'h0000) begin
			ramp_r <= ramp_r - 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_r <= 1'b0;
			fault_r <= 1'b0;
			abort_r <= 1'b0;
		end else begin
			power_r <= ctrl_r[`CTRL_AMP_EN] && !ot_r && !sync2_r[12] && !kill;
			fault_r <= ot_r || sync2_r[13];
			abort_r <= ot_r || sync2_r[12] || estop_r;
		end
	end

	// home search sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			home_st_r   <= HOME_IDLE;
			home_done_r <= 1'b0;
		end else if (abort_r) begin
			home_st_r <= HOME_IDLE;
		end else begin
			case (home_st_r)
				HOME_IDLE: begin
					if (wr_en && paddr == `OFS_CMD && pwdata[`CMD_HOME]) begin
						home_st_r   <= HOME_SEEK;
						home_done_r <= 1'b0;
					end
				end
				HOME_SEEK: begin
					if (home_act_r) begin
						home_st_r <= HOME_LEAVE;
					end
				end
				HOME_LEAVE: begin
					if (!home_act_r) begin
						if (ctrl_r[`CTRL_HOME_MARK]) begin
							home_st_r <= HOME_MARK;
						end else begin
							home_st_r   <= HOME_IDLE;
							home_done_r <= 1'b1;
						end
					end
				end
				HOME_MARK: begin
					if (qlink.idx_pulse) begin
						home_st_r   <= HOME_IDLE;
						home_done_r <= 1'b1;
					end
				end
				default: home_st_r <= HOME_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hmove_r <= 1'b0;
			hdir_r  <= 1'b0;
		end else begin
			hmove_r <= home_st_r != HOME_IDLE;
			hdir_r  <= (home_st_r == HOME_SEEK) ? ctrl_r[`CTRL_HOME_DIR] :
				~ctrl_r[`CTRL_HOME_DIR];
		end
	end

	// hall decode: inverted signals give the phase-positive pattern
	always_comb begin
		sector    = 3'h0;
		sector_ok = 1'b1;
		case (~sync2_r[10:8])
			3'b001: sector = 3'h0;
			3'b011: sector = 3'h1;
			3'b010: sector = 3'h2;
			3'b110: sector = 3'h3;
			3'b100: sector = 3'h4;
			3'b101: sector = 3'h5;
			default: sector_ok = 1'b0;
		endcase
		sec_sum = {1'b0, sector} + {1'b0, ctrl_r[`CTRL_HMAP_LSB +: 3]};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comm_r     <= 3'h0;
			hall_err_r <= 1'b0;
		end else begin
			hall_err_r <= ~sector_ok;
			if (sector_ok) begin
				comm_r <= (sec_sum >= 4'hc) ? 3'(sec_sum - 4'hc) :
					(sec_sum >= 4'h6) ? 3'(sec_sum - 4'h6) : sec_sum[2:0];
			end
		end
	end

	assign status = {15'h0000, fault_r, 1'b0, comm_r, 1'b0, hall_err_r, step_mode_r,
		stopped, power_r, hmove_r, home_done_r, home_act_r, ccw_act_r, cw_act_r,
		ot_r, estop_r};

	assign prdata         = prdata_r;
	assign pready         = pready_r;
	assign pslverr        = pslverr_r;
	assign power_stage_en = power_r;
	assign amp_fault_out  = fault_r;
	assign cw_inhibit     = cw_inh_r;
	assign ccw_inhibit    = ccw_inh_r;
	assign motion_abort   = abort_r;
	assign hold_ramp      = ramp_r;
	assign home_move      = hmove_r;
	assign home_dir       = hdir_r;
	assign step_pos       = step_pos_r;
	assign comm_state     = comm_r;
endmodule
`default_nettype wire

// File: motion_io_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module motion_io_checker #(
	parameter int unsigned ESTOP_CYC = 40000,
	parameter int unsigned SERVO_CYC = 40000
) (
	input wire logic        pclk,           // clock
	input wire logic        presetn,        // reset, active low
	input wire logic [7:0]  paddr,          // apb address
	input wire logic        pready,         // apb ready
	input wire logic        pslverr,        // apb error
	input wire logic        thermistor,     // over temperature pin
	input wire logic        amp_fault_in,   // power stage fault
	input wire logic        power_stage_en, // power on
	input wire logic        amp_fault_out,  // fault output
	input wire logic        motion_abort,   // abort
	input wire logic [15:0] hold_ramp,      // stop ramp
	input wire logic [31:0] step_pos,       // step command
	input wire logic [2:0]  comm_state      // sector
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] fsrc_r;
	// recent history of amplifier fault causes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fsrc_r <= 8'h00;
		else
			fsrc_r <= {fsrc_r[6:0], thermistor | amp_fault_in};
	end
	property p_fault_follow;
		amp_fault_in |-> ##[1:4] amp_fault_out;
	endproperty
	a_fault_follow: assert property (p_fault_follow) else $error("fault out missed");
	property p_fault_cause;
		$rose(amp_fault_out) |-> (|fsrc_r) || thermistor || amp_fault_in;
	endproperty
	a_fault_cause: assert property (p_fault_cause) else $error("fault out no cause");
	property p_ot_off;
		$rose(thermistor) |-> ##[1:6] (!power_stage_en && motion_abort);
	endproperty
	a_ot_off: assert property (p_ot_off) else $error("overtemp kept power");
	property p_ot_latch;
		(!amp_fault_in && !thermistor)[*6] ##0 (amp_fault_out && paddr != 8'h04) |=> amp_fault_out;
	endproperty
	a_ot_latch: assert property (p_ot_latch) else $error("overtemp latch lost");
	property p_step_hold;
		$changed(step_pos) |=> $stable(step_pos)[*8];
	endproperty
	a_step_hold: assert property (p_step_hold) else $error("step pos not per tick");
	property p_ramp_dec;
		($past(hold_ramp) != 16'h0 && $changed(hold_ramp))
			|-> (hold_ramp == $past(hold_ramp) - 16'h1 || hold_ramp == 16'h0);
	endproperty
	a_ramp_dec: assert property (p_ramp_dec) else $error("ramp step wrong");
	property p_comm_range;
		comm_state <= 3'h5;
	endproperty
	a_comm_range: assert property (p_comm_range) else $error("bad sector");
	property p_pready_pulse;
		pready |=> !pready;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse) else $error("ready too long");
	property p_slverr;
		pslverr |-> pready &&
			!(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h30});
	endproperty
	a_slverr: assert property (p_slverr) else $error("error on mapped address");
endmodule
bind motion_io_supervisor motion_io_checker #(.ESTOP_CYC(ESTOP_CYC), .SERVO_CYC(SERVO_CYC))
	u_motion_io_checker (.pclk(pclk), .presetn(presetn), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .thermistor(thermistor), .amp_fault_in(amp_fault_in),
	.power_stage_en(power_stage_en), .amp_fault_out(amp_fault_out),
	.motion_abort(motion_abort), .hold_ramp(hold_ramp), .step_pos(step_pos),
	.comm_state(comm_state));
`default_nettype wire

// File: motion_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module motion_far_side #(
	parameter int STEP_GAP = 40,
	parameter int EDGE_GAP = 4
) (
	input  wire logic pclk,     // system clock
	output var logic  step_clk, // step pin
	output var logic  step_dir, // direction pin
	output var logic  qa,       // encoder a
	output var logic  qb        // encoder b
);
	int         ph = 0;
	logic [1:0] gray [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
	initial begin
		step_clk = 1'b0;
		step_dir = 1'b0;
		qa = 1'b0;
		qb = 1'b0;
	end
	// one step per STEP_GAP + 1 cycles keeps the rate just under 1 MHz
	task automatic steps(input logic d, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk) step_dir <= d;
			repeat (STEP_GAP / 2) @(posedge pclk);
			step_clk <= 1'b1;
			repeat (STEP_GAP / 2) @(posedge pclk);
			step_clk <= 1'b0;
		end
	endtask
	task automatic enc(input int n);
		repeat (n < 0 ? -n : n) begin
			repeat (EDGE_GAP) @(posedge pclk);
			ph = (ph + (n < 0 ? 3 : 1)) % 4;
			{qa, qb} <= gray[ph];
		end
	endtask
	// both channels flip at once, twice
	task automatic enc_bad();
		repeat (2) begin
			repeat (EDGE_GAP) @(posedge pclk);
			{qa, qb} <= ~{qa, qb};
		end
	endtask
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "motion_io_supervisor_regs.svh"
module testbench;
	localparam int EC = 20;
	localparam int SC = 16;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, step_pos, r;
	logic        pready, pslverr, step_clk, step_dir, qa, qb, e;
	logic        cw_lim = 1'b1, ccw_lim = 1'b1, estop = 1'b0, therm = 1'b0, afi = 1'b0;
	logic [2:0]  hall = 3'b001, comm_state;
	logic [9:0]  adc_data = 10'h0;
	logic        adc_valid = 1'b0;
	logic        power_stage_en, amp_fault_out, cw_inhibit, ccw_inhibit, motion_abort;
	logic        home_move, home_dir;
	logic        home_lim = 1'b1, idx = 1'b0;
	logic [15:0] hold_ramp;
	int          num_errors = 0, checked = 0;
	logic [2:0]  hp [6] = '{3'b110, 3'b100, 3'b101, 3'b001, 3'b011, 3'b010};
	always #12.5 pclk = ~pclk;
	motion_io_supervisor #(.ESTOP_CYC(EC), .SERVO_CYC(SC)) u_motion_io_supervisor (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.step_clk(step_clk), .step_dir(step_dir), .encoder_channel_a(qa),
		.encoder_channel_b(qb), .encoder_index_pulse(idx),
		.clockwise_travel_stop(cw_lim), .counterclockwise_travel_stop(ccw_lim),
		.home_limit(home_lim), .hall(hall), .estop(estop), .thermistor(therm),
		.amp_fault_in(afi), .adc_data(adc_data), .adc_valid(adc_valid),
		.power_stage_en(power_stage_en), .amp_fault_out(amp_fault_out),
		.cw_inhibit(cw_inhibit), .ccw_inhibit(ccw_inhibit), .motion_abort(motion_abort),
		.hold_ramp(hold_ramp), .home_move(home_move), .home_dir(home_dir),
		.step_pos(step_pos),
		.comm_state(comm_state));
	motion_far_side u_motion_far_side (.pclk(pclk), .step_clk(step_clk),
		.step_dir(step_dir), .qa(qa), .qb(qb));
	task automatic stop_test();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x) begin
			$display("[ERR] %0t got %h exp %h", $time, g, x);
			num_errors++;
		end
	endtask
	task automatic chb(input logic g, input logic x);
		chk({31'h0, g}, {31'h0, x});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			$display("[ERR] %0t pready got %h exp %h", $time, pready, 1'b1);
			num_errors++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
	endtask
	task automatic t_regs();
		rd(`OFS_CTRL, `CTRL_RST);
		rd(`OFS_RAMP, {16'h0, `RAMP_RST});
		rd(`OFS_CMD, 32'h0);
		wr(8'h40, 32'hffff_ffff);
		chb(e, 1'b1);
		rd(8'h40, 32'h0);
		$display("register test done");
	endtask
	task automatic t_step();
		u_motion_far_side.steps(1'b1, 2);
		cyc(2 * SC);
		rd(`OFS_STEP_POS, 32'h0);
		wr(`OFS_CTRL, 32'h0002_0005);
		wr(`OFS_CMD, 32'h4);
		u_motion_far_side.steps(1'b1, 3);
		u_motion_far_side.steps(1'b0, 1);
		cyc(2 * SC);
		chk(step_pos, 32'h2);
		@(posedge pclk) cw_lim <= 1'b0;
		cyc(6);
		chb(cw_inhibit, 1'b1);
		chb(ccw_inhibit, 1'b0);
		u_motion_far_side.steps(1'b1, 2);
		u_motion_far_side.steps(1'b0, 1);
		cyc(2 * SC);
		rd(`OFS_STEP_POS, 32'h1);
		wr(`OFS_CTRL, 32'h0002_3005);
		cyc(6);
		chb(cw_inhibit, 1'b0);
		chb(ccw_inhibit, 1'b1);
		@(posedge pclk) cw_lim <= 1'b1;
		cyc(6);
		chb(cw_inhibit, 1'b1);
		wr(`OFS_CTRL, 32'h0002_0005);
		$display("step test done");
	endtask
	task automatic t_estop(input logic [1:0] act);
		wr(`OFS_RAMP, 32'h3);
		wr(`OFS_CTRL, 32'h0006_0004 | {26'h0, act, 4'h0});
		cyc(6);
		chb(power_stage_en, 1'b1);
		@(posedge pclk) estop <= 1'b1;
		cyc(EC + 8);
		chb(motion_abort, 1'b1);
		chb(power_stage_en, act != 2'h0 && act != 2'h3);
		if (act == 2'h1 || act == 2'h2)
			chb(hold_ramp != 16'h0, 1'b1);
		cyc(4 * SC);
		chk({16'h0, hold_ramp}, 32'h0);
		chb(power_stage_en, act == 2'h1);
		@(posedge pclk) estop <= 1'b0;
		cyc(EC + 8);
		$display("estop action %0d test done", act);
	endtask
	task automatic t_temp();
		@(posedge pclk) afi <= 1'b1;
		cyc(6);
		chb(amp_fault_out, 1'b1);
		@(posedge pclk) afi <= 1'b0;
		cyc(6);
		chb(amp_fault_out, 1'b0);
		@(posedge pclk) therm <= 1'b1;
		cyc(6);
		chb(power_stage_en, 1'b0);
		rd(`OFS_STATUS, 32'h0001_3202);
		chb(r[1], 1'b1);
		@(posedge pclk) therm <= 1'b0;
		cyc(8);
		chb(amp_fault_out, 1'b1);
		chb(power_stage_en, 1'b0);
		wr(`OFS_CMD, 32'h1);
		cyc(6);
		chb(amp_fault_out, 1'b0);
		chb(power_stage_en, 1'b1);
		$display("temperature test done");
	endtask
	task automatic t_misc();
		logic [31:0] p0;
		apb(1'b0, `OFS_ENC_POS, 32'h0, p0, e);
		u_motion_far_side.enc(6);
		u_motion_far_side.enc(-2);
		u_motion_far_side.enc_bad();
		cyc(8);
		rd(`OFS_ENC_POS, p0 + 32'h4);
		@(posedge pclk) adc_data <= 10'h2a5;
		@(posedge pclk) adc_valid <= 1'b1;
		@(posedge pclk) adc_valid <= 1'b0;
		rd(`OFS_ADC, 32'h2a5);
		for (int i = 0; i < 6; i++) begin
			@(posedge pclk) hall <= hp[i];
			cyc(6);
			chk({29'h0, comm_state}, i);
		end
		wr(`OFS_CTRL, 32'h0006_0204);
		cyc(6);
		chk({29'h0, comm_state}, 32'h1);
		$display("encoder adc hall test done");
	endtask
	task automatic t_home();
		wr(`OFS_CTRL, 32'h0007_0004);
		wr(`OFS_CMD, 32'h2);
		cyc(3);
		chb(home_move, 1'b1);
		chb(home_dir, 1'b1);
		@(posedge pclk) home_lim <= 1'b0;
		cyc(6);
		chb(home_dir, 1'b0);
		@(posedge pclk) home_lim <= 1'b1;
		cyc(6);
		chb(home_move, 1'b1);
		@(posedge pclk) idx <= 1'b1;
		cyc(6);
		chb(home_move, 1'b0);
		apb(1'b0, `OFS_STATUS, 32'h0, r, e);
		chb(r[5], 1'b1);
		@(posedge pclk) idx <= 1'b0;
		$display("home test done");
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_step();
		for (int a = 0; a < 4; a++)
			t_estop(a[1:0]);
		t_temp();
		t_misc();
		t_home();
		stop_test();
	end
endmodule
`default_nettype wire
